// ===== design/ofm_regs.sv
`timescale 1ns/10ps
`default_nettype none
module ofm_regs
    import ofm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [7:0]  nv_fault_mask_init,
    input  wire logic [31:0] nv_password_init,
    input  wire logic [31:0] stored_pw_low,
    input  wire logic [31:0] stored_pw_high,
    input  wire logic        oem_config_six_pw_sel,
    input  wire logic        warm_reset,
    input  wire logic        fault_saturation,
    input  wire logic        fault_tx_power,
    input  wire logic        alarm_bias_high,
    input  wire logic        fault_diode,
    input  wire logic        oem_irq_source,
    input  wire logic        signal_loss_in,
    output logic             int_n,
    output logic             transmit_fault_output,
    output logic             receive_signal_loss_output,
    output logic             oem_access_granted,
    output logic             hour_meter_enable,
    output logic             comparator_channel_hold,
    output logic             power_loop_calibration,
    output logic             nvram_write_block,
    output logic             nv_wr_stb,
    output logic [7:0]       nv_wr_addr,
    output logic [7:0]       nv_wr_data
);

    // ------------------------------------------------------------
    // pin synchronisers and bus conditions
    // ------------------------------------------------------------
    logic [1:0]    scl_sync_q;
    logic [1:0]    sda_sync_q;
    logic          scl_prev_q;
    logic          sda_prev_q;
    logic          bus_start;
    logic          bus_stop;
    logic          scl_rise;
    logic          scl_fall;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    assign bus_start = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
    assign bus_stop  = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
    assign scl_rise  = scl_sync_q[1] & ~scl_prev_q;
    assign scl_fall  = ~scl_sync_q[1] & scl_prev_q;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0]    fault_mask_q;
    logic [31:0]   oem_password_setting_q;
    logic [31:0]   active_pw_q;
    logic [7:0]    calibration_test_control_q;
    logic          boot_q;
    logic          pw_valid;
    logic          reg_wr;
    logic [7:0]    ptr_q;
    logic [7:0]    shift_q;

    // first cycle after reset restores non-volatile contents
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fault_mask_q <= OFM_FAULT_MASK_RST;
        end else if (boot_q) begin
            fault_mask_q <= nv_fault_mask_init & OFM_FM_WRITABLE;
        end else if (reg_wr && ptr_q == OFM_FAULT_MASK_OFS) begin
            fault_mask_q <= shift_q & OFM_FM_WRITABLE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            oem_password_setting_q <= OFM_PW_RST;
        end else if (boot_q) begin
            oem_password_setting_q <= nv_password_init;
        end else if (reg_wr) begin
            unique case (ptr_q)
                OFM_PW_OFS_MSB: oem_password_setting_q[31:24] <= shift_q;
                OFM_PW_OFS_2:   oem_password_setting_q[23:16] <= shift_q;
                OFM_PW_OFS_3:   oem_password_setting_q[15:8]  <= shift_q;
                OFM_PW_OFS_LSB: oem_password_setting_q[7:0]   <= shift_q;
                default: ;
            endcase
        end
    end

    // comparison value only follows the setting on a reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            active_pw_q <= OFM_PW_RST;
        end else if (boot_q) begin
            active_pw_q <= nv_password_init;
        end else if (warm_reset) begin
            active_pw_q <= oem_password_setting_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            calibration_test_control_q <= OFM_CAL_RST;
        end else if (reg_wr && ptr_q == OFM_CAL_OFS) begin
            calibration_test_control_q <= shift_q & OFM_CAL_WRITABLE;
        end
    end

    assign pw_valid = oem_config_six_pw_sel ? (active_pw_q == stored_pw_high)
                                            : (active_pw_q == stored_pw_low);
    assign oem_access_granted = pw_valid;

    // ------------------------------------------------------------
    // non-volatile write-back
    // ------------------------------------------------------------
    function automatic logic is_nv_offset(input logic [7:0] ofs);
        return ofs >= OFM_FAULT_MASK_OFS && ofs <= OFM_PW_OFS_LSB;
    endfunction

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            nv_wr_stb  <= 1'b0;
            nv_wr_addr <= 8'h00;
            nv_wr_data <= 8'h00;
        end else begin
            nv_wr_stb <= reg_wr && is_nv_offset(ptr_q)
                         && !calibration_test_control_q[OFM_CAL_NV_BLOCK];
            if (reg_wr) begin
                nv_wr_addr <= ptr_q;
                nv_wr_data <= ptr_q == OFM_FAULT_MASK_OFS ? (shift_q & OFM_FM_WRITABLE)
                                                          : shift_q;
            end
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    function automatic logic [7:0] read_byte(input logic [7:0] ofs,
                                             input logic       granted);
        logic [7:0] val;
        val = 8'h00;
        if (!granted) begin
            val = OFM_DENIED_READ;
        end else begin
            unique case (ofs)
                OFM_FAULT_MASK_OFS: val = fault_mask_q;
                OFM_PW_OFS_MSB:     val = oem_password_setting_q[31:24];
                OFM_PW_OFS_2:       val = oem_password_setting_q[23:16];
                OFM_PW_OFS_3:       val = oem_password_setting_q[15:8];
                OFM_PW_OFS_LSB:     val = oem_password_setting_q[7:0];
                OFM_CAL_OFS:        val = calibration_test_control_q;
                default:            val = 8'h00;
            endcase
        end
        return val;
    endfunction

    logic [7:0]    rd_now;
    logic [7:0]    rd_next;

    always_comb begin
        rd_now  = read_byte(ptr_q, pw_valid);
        rd_next = read_byte(ptr_q + 8'h01, pw_valid);
    end

    // ------------------------------------------------------------
    // serial slave
    // ------------------------------------------------------------
    ofm_state_type state_q;
    logic [3:0]    bit_cnt_q;
    logic          read_mode_q;
    logic          sda_low_q;
    logic [7:0]    tx_q;

    assign reg_wr = state_q == OFM_WDATA && scl_fall && bit_cnt_q == OFM_LAST_BIT
                    && pw_valid;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_q <= 8'h00;
        end else if (scl_rise && bit_cnt_q != OFM_ACK_BIT) begin
            shift_q <= {shift_q[6:0], sda_sync_q[1]};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q     <= OFM_IDLE;
            bit_cnt_q   <= 4'h0;
            read_mode_q <= 1'b0;
            sda_low_q   <= 1'b0;
            tx_q        <= 8'h00;
            ptr_q       <= 8'h00;
        end else if (bus_stop) begin
            state_q   <= OFM_IDLE;
            sda_low_q <= 1'b0;
        end else if (bus_start) begin
            state_q   <= OFM_DEVADDR;
            // scl fall that closes the start is not a bit; wraps to 0 there
            bit_cnt_q <= 4'hf;
            sda_low_q <= 1'b0;
        end else if (state_q == OFM_RDATA && scl_rise && bit_cnt_q == OFM_ACK_BIT
                     && sda_sync_q[1]) begin
            state_q <= OFM_WAIT_STOP;
        end else if (scl_fall && state_q != OFM_IDLE && state_q != OFM_WAIT_STOP) begin
            if (bit_cnt_q == OFM_LAST_BIT) begin
                bit_cnt_q <= OFM_ACK_BIT;
                unique case (state_q)
                    OFM_DEVADDR: begin
                        if (shift_q[7:1] == OFM_DEV_ADDR) begin
                            sda_low_q   <= 1'b1;
                            read_mode_q <= shift_q[0];
                        end else begin
                            state_q <= OFM_WAIT_STOP;
                        end
                    end
                    OFM_POINTER: begin
                        ptr_q     <= shift_q;
                        sda_low_q <= 1'b1;
                    end
                    OFM_WDATA: begin
                        ptr_q     <= ptr_q + 8'h01;
                        sda_low_q <= 1'b1;
                    end
                    OFM_RDATA: begin
                        sda_low_q <= 1'b0;
                    end
                    default: ;
                endcase
            end else if (bit_cnt_q == OFM_ACK_BIT) begin
                bit_cnt_q <= 4'h0;
                sda_low_q <= 1'b0;
                unique case (state_q)
                    OFM_DEVADDR: begin
                        if (read_mode_q) begin
                            state_q   <= OFM_RDATA;
                            tx_q      <= rd_now;
                            sda_low_q <= ~rd_now[7];
                        end else begin
                            state_q <= OFM_POINTER;
                        end
                    end
                    OFM_POINTER: state_q <= OFM_WDATA;
                    OFM_RDATA: begin
                        ptr_q     <= ptr_q + 8'h01;
                        tx_q      <= rd_next;
                        sda_low_q <= ~rd_next[7];
                    end
                    default: ;
                endcase
            end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                if (state_q == OFM_RDATA) begin
                    tx_q      <= {tx_q[6:0], 1'b0};
                    sda_low_q <= ~tx_q[6];
                end
            end
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = sda_low_q;

    // ------------------------------------------------------------
    // control outputs and fault combining
    // ------------------------------------------------------------
    logic          cmp_open;
    logic          fault_any;
    logic          irq_any;

    assign hour_meter_enable       = fault_mask_q[OFM_FM_HOUR_EN];
    assign comparator_channel_hold = calibration_test_control_q[OFM_CAL_CHAN_HOLD];
    assign power_loop_calibration  = calibration_test_control_q[OFM_CAL_LOOP_CAL];
    assign nvram_write_block       = calibration_test_control_q[OFM_CAL_NV_BLOCK];

    assign cmp_open = ~calibration_test_control_q[OFM_CAL_CMP_BLOCK];

    assign fault_any = cmp_open & (
          (fault_saturation & ~fault_mask_q[OFM_FM_SAT_MASK])
        | (fault_tx_power   & ~fault_mask_q[OFM_FM_TXP_MASK])
        | (alarm_bias_high  & ~fault_mask_q[OFM_FM_BIAS_MASK])
        | (fault_diode      & ~fault_mask_q[OFM_FM_DIODE_MASK]));

    assign irq_any = fault_any
                   | (oem_irq_source & ~fault_mask_q[OFM_FM_IRQ_MASK]);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_n                      <= 1'b1;
            transmit_fault_output      <= 1'b0;
            receive_signal_loss_output <= 1'b0;
        end else begin
            int_n <= ~(irq_any | calibration_test_control_q[OFM_CAL_FORCE_IRQ]);
            transmit_fault_output <= fault_any
                | calibration_test_control_q[OFM_CAL_FORCE_TXF];
            receive_signal_loss_output <= signal_loss_in
                | calibration_test_control_q[OFM_CAL_FORCE_LOS];
        end
    end

endmodule
`default_nettype wire

// ===== design/ofm_pkg.sv
// Function
// - fault mask byte kept non-volatile, zero by default, restored after reset.
// - fault mask bit 7 set masks the oem interrupt source.
// - fault mask bit 6 set enables the power-on hour meter.
// - reserved bits written as zero by host; reads return zero.
// - fault mask bit 3 set masks the power loop saturation fault.
// - fault mask bit 2 set masks the high transmit power fault.
// - fault mask bit 1 set masks the bias current high alarm.
// - fault mask bit 0 set masks the laser diode fault.
// - password setting at offsets 12 to 15, offset 12 most significant.
// - compare active password with stored bytes 120-123 or 123-126 per config bit.
// - matching passwords grant oem memory access, otherwise denied.
// - new password takes effect only after power-on or warm reset.
// - these registers accessible only while a valid password is in effect.
// - calibration bit 6 blocks fault comparator outputs.
// - calibration bit 4 suppresses all nvram write cycles.
// - calibration bit 3 places the power loop in calibration mode.
// - calibration bit 2 forces the active-low interrupt output asserted.
// - calibration bit 1 forces the transmit fault output asserted.
// - calibration bit 0 forces the receive signal loss output asserted.
package ofm_pkg;
    // ------------------------------------------------------------
    // serial bus
    // ------------------------------------------------------------
    localparam logic [6:0] OFM_DEV_ADDR     = 7'h53;
    localparam logic [3:0] OFM_ACK_BIT      = 4'h8;
    localparam logic [3:0] OFM_LAST_BIT     = 4'h7;
    localparam logic [7:0] OFM_DENIED_READ  = 8'hff;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFM_FAULT_MASK_OFS = 8'h0b;
    localparam logic [7:0] OFM_PW_OFS_MSB     = 8'h0c;
    localparam logic [7:0] OFM_PW_OFS_2       = 8'h0d;
    localparam logic [7:0] OFM_PW_OFS_3       = 8'h0e;
    localparam logic [7:0] OFM_PW_OFS_LSB     = 8'h0f;
    localparam logic [7:0] OFM_CAL_OFS        = 8'h10;

    // ------------------------------------------------------------
    // fault mask fields
    // ------------------------------------------------------------
    localparam int OFM_FM_IRQ_MASK  = 7;
    localparam int OFM_FM_HOUR_EN   = 6;
    localparam int OFM_FM_SAT_MASK  = 3;
    localparam int OFM_FM_TXP_MASK  = 2;
    localparam int OFM_FM_BIAS_MASK = 1;
    localparam int OFM_FM_DIODE_MASK = 0;
    localparam logic [7:0] OFM_FM_WRITABLE = 8'hcf;

    // ------------------------------------------------------------
    // calibration control fields
    // ------------------------------------------------------------
    localparam int OFM_CAL_CMP_BLOCK  = 6;
    localparam int OFM_CAL_CHAN_HOLD  = 5;
    localparam int OFM_CAL_NV_BLOCK   = 4;
    localparam int OFM_CAL_LOOP_CAL   = 3;
    localparam int OFM_CAL_FORCE_IRQ  = 2;
    localparam int OFM_CAL_FORCE_TXF  = 1;
    localparam int OFM_CAL_FORCE_LOS  = 0;
    localparam logic [7:0] OFM_CAL_WRITABLE = 8'h7f;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  OFM_FAULT_MASK_RST = 8'h00;
    localparam logic [31:0] OFM_PW_RST         = 32'h0000_0000;
    localparam logic [7:0]  OFM_CAL_RST        = 8'h00;

    typedef enum logic [2:0] {
        OFM_IDLE,
        OFM_DEVADDR,
        OFM_POINTER,
        OFM_WDATA,
        OFM_RDATA,
        OFM_WAIT_STOP
    } ofm_state_type;
endpackage

// ===== verification/ofm_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module ofm_regs_props
    import ofm_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        warm_reset,
    input wire logic [31:0] stored_pw_low,
    input wire logic [31:0] stored_pw_high,
    input wire logic        oem_config_six_pw_sel,
    input wire logic        signal_loss_in,
    input wire logic        receive_signal_loss_output,
    input wire logic        oem_access_granted,
    input wire logic        hour_meter_enable,
    input wire logic        power_loop_calibration,
    input wire logic        nvram_write_block,
    input wire logic        nv_wr_stb,
    input wire logic [7:0]  nv_wr_addr,
    input wire logic [7:0]  nv_wr_data
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    property p_nv_blocked;
        nvram_write_block |-> !nv_wr_stb;
    endproperty
    a_nv_blocked: assert property (p_nv_blocked)
        else $error("nv strobe while blocked");
    property p_stb_granted;
        nv_wr_stb |-> oem_access_granted;
    endproperty
    a_stb_granted: assert property (p_stb_granted)
        else $error("nv strobe without password");
    property p_stb_addr;
        nv_wr_stb |-> nv_wr_addr inside {[OFM_FAULT_MASK_OFS:OFM_PW_OFS_LSB]};
    endproperty
    a_stb_addr: assert property (p_stb_addr)
        else $error("nv strobe to volatile offset");
    property p_stb_pulse;
        nv_wr_stb |=> !nv_wr_stb;
    endproperty
    a_stb_pulse: assert property (p_stb_pulse)
        else $error("nv strobe longer than one cycle");
    property p_rsvd_zero;
        nv_wr_stb && nv_wr_addr == OFM_FAULT_MASK_OFS |-> nv_wr_data[5:4] == 2'b00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved mask bits stored nonzero");
    property p_los;
        signal_loss_in |=> receive_signal_loss_output;
    endproperty
    a_los: assert property (p_los)
        else $error("signal loss not passed to output");
    property p_pw_hold;
        $past(resetn, 2) && !$past(warm_reset) && $stable(stored_pw_low)
            && $stable(stored_pw_high) && $stable(oem_config_six_pw_sel)
            |-> $stable(oem_access_granted);
    endproperty
    a_pw_hold: assert property (p_pw_hold)
        else $error("access changed without warm reset");
    property p_ctrl_granted;
        $past(resetn, 2) && ($changed(hour_meter_enable) || $changed(nvram_write_block)
            || $changed(power_loop_calibration)) |-> oem_access_granted;
    endproperty
    a_ctrl_granted: assert property (p_ctrl_granted)
        else $error("control changed without password");
    c_nv_write: cover property (nv_wr_stb);
    c_grant_rise: cover property ($rose(oem_access_granted));
    c_grant_fall: cover property ($fell(oem_access_granted));
endmodule
bind ofm_regs ofm_regs_props u_props (
    .clk, .resetn, .warm_reset, .stored_pw_low, .stored_pw_high, .oem_config_six_pw_sel,
    .signal_loss_in, .receive_signal_loss_output, .oem_access_granted, .hour_meter_enable,
    .power_loop_calibration, .nvram_write_block, .nv_wr_stb, .nv_wr_addr, .nv_wr_data
);
`default_nettype wire

// ===== verification/ofm_host.sv
`timescale 1ns/10ps
`default_nettype none
module ofm_host
    import ofm_pkg::*;
(
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    logic ack_ok;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        ack_ok = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // drive mid-low, sample mid-high, clock idles high
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        sda_pull = ~b;
        tick(4);
        scl = 1'b1;
        tick(4);
        r = sda;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic byte_io(input logic [7:0] d, input logic ack_in, input logic chk,
                           output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ack_in, a);
        if (chk && a !== 1'b0) ack_ok = 1'b0;
    endtask
    task automatic start_c();
        tick(4);
        sda_pull = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(6);
        sda_pull = 1'b1;
        tick(6);
        scl = 1'b0;
    endtask
    task automatic stop_c();
        tick(4);
        sda_pull = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(6);
        sda_pull = 1'b0;
        tick(8);
    endtask
    // msb first; reads nack the last byte
    task automatic xfer(input logic [7:0] ofs, input logic [31:0] d, input int n,
                        input logic rd, output logic [31:0] q);
        logic [7:0] b;
        q = 32'h0000_0000;
        start_c();
        byte_io({OFM_DEV_ADDR, 1'b0}, 1'b1, 1'b1, b);
        byte_io(ofs, 1'b1, 1'b1, b);
        if (rd) begin
            start_c();
            byte_io({OFM_DEV_ADDR, 1'b1}, 1'b1, 1'b1, b);
        end
        for (int i = n - 1; i >= 0; i--) begin
            byte_io(rd ? 8'hff : d[8*i+:8], rd ? (i == 0) : 1'b1, !rd, b);
            q = {q[23:0], b};
        end
        stop_c();
    endtask
endmodule
`default_nettype wire

// ===== verification/ofm_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ofm_regs_tb_top
    import ofm_pkg::*;
    ;
    logic        clk = 1'b0;
    logic        resetn;
    logic        scl;
    logic        sda_pull;
    logic        sda_out;
    logic        sda_oe;
    logic        sda_line;
    logic        warm_reset;
    logic        sel;
    logic [3:0]  flt;
    logic        irq_src;
    logic        los_in;
    logic [31:0] stored_hi;
    logic [31:0] stored_lo;
    logic [7:0]  nv_mask_init;
    logic [31:0] nv_pw_init;
    logic [7:0]  nv_addr;
    logic [7:0]  nv_data;
    logic [15:0] last_nv = 16'h0000;
    logic        int_n;
    logic        txf;
    logic        rxl;
    logic        granted;
    logic        hme;
    logic        chold;
    logic        ploop;
    logic        nvblk;
    logic        nv_stb;
    logic [31:0] q;
    int          stb_count = 0;
    int          n0;
    int          cycles = 0;
    int          bad_count = 0;
    int          total_checks = 0;
    assign sda_line = ~sda_pull & (sda_oe ? sda_out : 1'b1);
    always #12.5 clk = ~clk;
    ofm_host u_host (.clk(clk), .sda(sda_line), .scl(scl), .sda_pull(sda_pull));
    ofm_regs u_dut (
        .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .nv_fault_mask_init(nv_mask_init), .nv_password_init(nv_pw_init),
        .stored_pw_low(stored_lo), .stored_pw_high(stored_hi),
        .oem_config_six_pw_sel(sel), .warm_reset(warm_reset),
        .fault_saturation(flt[3]), .fault_tx_power(flt[2]),
        .alarm_bias_high(flt[1]), .fault_diode(flt[0]),
        .oem_irq_source(irq_src), .signal_loss_in(los_in),
        .int_n(int_n), .transmit_fault_output(txf), .receive_signal_loss_output(rxl),
        .oem_access_granted(granted), .hour_meter_enable(hme),
        .comparator_channel_hold(chold), .power_loop_calibration(ploop),
        .nvram_write_block(nvblk), .nv_wr_stb(nv_stb), .nv_wr_addr(nv_addr),
        .nv_wr_data(nv_data)
    );
    task automatic give_verdict();
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic wr8(input logic [7:0] ofs, input logic [7:0] d);
        u_host.xfer(ofs, {24'h00_0000, d}, 1, 1'b0, q);
    endtask
    task automatic rd8(input logic [7:0] ofs, input logic [7:0] exp);
        u_host.xfer(ofs, 32'h0000_0000, 1, 1'b1, q);
        chk(q, {24'h00_0000, exp});
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (nv_stb === 1'b1) begin
            stb_count <= stb_count + 1;
            last_nv   <= {nv_addr, nv_data};
        end
        if (cycles == 80000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        {resetn, warm_reset, sel, flt, irq_src, los_in} = '0;
        stored_hi = 32'hdead_beef;
        stored_lo = 32'h1234_5678;
        nv_mask_init = 8'hff;
        nv_pw_init = 32'h1234_5678;
        repeat (5) @(posedge clk);
        #1;
        resetn = 1'b1;
        u_host.tick(4);
        rd8(OFM_FAULT_MASK_OFS, 8'hcf);
        chk({hme, granted}, 2'b11);
        u_host.xfer(OFM_PW_OFS_MSB, 32'h0000_0000, 4, 1'b1, q);
        chk(q, 32'h1234_5678);
        for (int i = 0; i < 4; i++) begin
            wr8(OFM_FAULT_MASK_OFS, 8'h01 << i);
            flt = 4'h1 << i;
            u_host.tick(3);
            chk({txf, int_n}, 2'b01);
            chk(last_nv, {OFM_FAULT_MASK_OFS, 8'h01 << i});
            n0 = stb_count;
            wr8(OFM_FAULT_MASK_OFS, 8'h00);
            chk({txf, int_n, 4'(stb_count - n0)}, {2'b10, 4'h1});
            flt = 4'h0;
        end
        wr8(OFM_FAULT_MASK_OFS, 8'h80);
        irq_src = 1'b1;
        u_host.tick(3);
        chk(int_n, 1'b1);
        wr8(OFM_FAULT_MASK_OFS, 8'h00);
        chk(int_n, 1'b0);
        irq_src = 1'b0;
        flt = 4'h1;
        wr8(OFM_CAL_OFS, 8'h40);
        chk({txf, int_n}, 2'b01);
        n0 = stb_count;
        wr8(OFM_CAL_OFS, 8'h10);
        wr8(OFM_FAULT_MASK_OFS, 8'h01);
        chk({nvblk, 4'(stb_count - n0)}, {1'b1, 4'h0});
        rd8(OFM_FAULT_MASK_OFS, 8'h01);
        flt = 4'h0;
        wr8(OFM_CAL_OFS, 8'h7f);
        rd8(OFM_CAL_OFS, 8'h7f);
        chk({chold, ploop, nvblk, int_n, txf, rxl}, 6'b111011);
        wr8(OFM_CAL_OFS, 8'h00);
        chk({ploop, int_n, txf, rxl}, 4'b0100);
        los_in = 1'b1;
        u_host.tick(3);
        chk(rxl, 1'b1);
        los_in = 1'b0;
        n0 = stb_count;
        u_host.xfer(OFM_PW_OFS_MSB, 32'haabb_ccdd, 4, 1'b0, q);
        chk({granted, 4'(stb_count - n0)}, {1'b1, 4'h4});
        chk(last_nv, {OFM_PW_OFS_LSB, 8'hdd});
        u_host.xfer(OFM_PW_OFS_MSB, 32'h0000_0000, 4, 1'b1, q);
        chk(q, 32'haabb_ccdd);
        warm_reset = 1'b1;
        u_host.tick(1);
        warm_reset = 1'b0;
        u_host.tick(1);
        chk(granted, 1'b0);
        rd8(OFM_FAULT_MASK_OFS, OFM_DENIED_READ);
        n0 = stb_count;
        wr8(OFM_FAULT_MASK_OFS, 8'h40);
        chk({hme, 4'(stb_count - n0)}, {1'b0, 4'h0});
        stored_hi = 32'haabb_ccdd;
        sel = 1'b1;
        u_host.tick(2);
        chk(granted, 1'b1);
        rd8(OFM_FAULT_MASK_OFS, 8'h01);
        sel = 1'b0;
        u_host.tick(2);
        chk(granted, 1'b0);
        resetn = 1'b0;
        nv_mask_init = 8'h71;
        nv_pw_init = 32'haabb_ccdd;
        stored_lo = 32'haabb_ccdd;
        u_host.tick(2);
        resetn = 1'b1;
        u_host.tick(4);
        rd8(OFM_FAULT_MASK_OFS, 8'h41);
        chk({hme, granted}, 2'b11);
        chk(u_host.ack_ok, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
